/* File: bench/serial_frame_sync_error_mux_tb.sv */
`timescale 1ns/1ps
module serial_frame_sync_error_mux_tb;
  reg         clk_sys_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg  [3:0]  addr_i = 4'h0;
  reg  [31:0] wdata_i = 32'h0000_0000;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg         conv_start_i = 1'b0;
  reg  [15:0] conv_data_i = 16'h0000;
  reg         go = 1'b0;
  reg  [4:0]  n = 5'h10;
  reg  [31:0] s = 32'h8d34_ca0f;
  reg  [31:0] rv;
  wire [31:0] rdata_o;
  wire [15:0] w;
  wire        ext_sclk_i, irq_o, busy_o, serial_clk_o, serial_data_out_o, pin_ten_o, pin_eleven_o;
  integer     n_mismatch = 0;
  integer     samples_checked = 0;
  integer     i, j;
  integer     n_flag = 0;
  always @(posedge clk_sys_i) if (pin_eleven_o === 1'b1) n_flag = n_flag + 1;
  always #4 clk_sys_i = ~clk_sys_i;
  sfsem_top i_dut (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .conv_start_i,
    .conv_data_i, .ext_sclk_i, .busy_o, .serial_clk_o, .serial_data_out_o, .pin_ten_o, .pin_eleven_o);
  sfsem_host i_host (.go_i(go), .n_i(n), .sdo_i(serial_data_out_o), .sclk_o(ext_sclk_i), .word_o(w));
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [31:0] par(input [15:0] d);
    par = {30'h0, d[11:10]};
  endfunction
  task chk(input [39:0] t, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s exp %h got %h", t, e, g);
      end
    end
  endtask
  task bus(input r, input [3:0] a, input [31:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      rd_i <= r;
      wr_i <= !r;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      wr_i <= 1'b0;
      #1 rv = rdata_o;
      @(posedge clk_sys_i);
    end
  endtask
  task conv(input [15:0] d);
    begin
      conv_data_i <= d;
      conv_start_i <= 1'b1;
      @(posedge clk_sys_i);
      conv_start_i <= 1'b0;
      repeat (84) @(posedge clk_sys_i);
    end
  endtask
  task frame(input [4:0] b);
    begin
      n <= b;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
    end
  endtask
  task conclude;
    begin
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    for (i = 0; i < 6; i = i + 1) begin
      s = nxt(s);
      conv(i < 2 ? {16{i[0]}} : s[15:0]);
      chk("par", par(conv_data_i), {30'h0, pin_eleven_o, pin_ten_o});
    end
    bus(1'b0, 4'h8, 32'h0000_0003);
    chk("irq", 1, irq_o);
    bus(1'b0, 4'h4, 32'h0000_0001);
    chk("irq", 0, irq_o);
    bus(1'b1, 4'h2, 32'h0000_0000);
    chk("unmap", 0, rv);
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b0, 4'h0, {29'h0, i[0], 2'b01});
      conv(s[15:0]);
      for (j = 0; j < 40 && serial_clk_o !== 1'b1; j = j + 1) @(posedge clk_sys_i);
      chk("sync", !i[0], pin_ten_o);
      if (j == 40) begin
        n_mismatch = n_mismatch + 1;
        conclude;
      end
      // let the whole internal read drain before the mode moves
      repeat (300) @(posedge clk_sys_i);
    end
    bus(1'b0, 4'h0, 32'h0000_0003);
    conv(s[31:16]);
    frame(5'h10);
    repeat (340) @(posedge clk_sys_i);
    chk("word", s[31:16], w);
    conv(16'h1234);
    frame(5'h04);
    repeat (100) @(posedge clk_sys_i);
    j = n_flag;
    conv(16'h4321);
    chk("pulse", j + 1, n_flag);
    bus(1'b1, 4'h4, 32'h0000_0000);
    chk("ovr", 1, rv[1]);
    bus(1'b1, 4'hC, 32'h0000_0000);
    chk("res", 16'h1234, rv[15:0]);
    chk("flag", 0, pin_eleven_o);
    conclude;
  end
endmodule

/* File: bench/sfsem_chk.sv */
`timescale 1ns/1ps
module sfsem_chk (
  input wire        clk_sys_i,
  input wire        nrst_i,
  input wire [3:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        conv_start_i,
  input wire [15:0] conv_data_i,
  input wire        busy_o,
  input wire        serial_clk_o,
  input wire        pin_ten_o,
  input wire        pin_eleven_o
);
  reg  [2:0]  c_q;
  reg  [2:0]  h_q;
  reg  [15:0] r_q;
  // quiet: pins may lag a write or a completion by two cycles
  wire        q = !busy_o && h_q[1:0] == 2'b00;
  always @(posedge clk_sys_i) begin
    h_q <= {h_q[1:0], busy_o | wr_i};
    if (!nrst_i) r_q <= 16'h0000;
    else if (busy_o) r_q <= conv_data_i;
    if (!nrst_i) c_q <= 3'h0;
    else if (wr_i && addr_i == 4'h0) c_q <= wdata_i[2:0];
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  ten_par_a: assert property (!c_q[0] && q |-> pin_ten_o == r_q[10]) else $error("ten");
  elv_par_a: assert property (!c_q[0] && q |-> pin_eleven_o == r_q[11]) else $error("eleven");
  sync_on_a: assert property (c_q[1:0] == 2'b01 && $fell(busy_o) |-> ##[1:2] pin_ten_o == !c_q[2])
    else $error("sync");
  sync_hi_a: assert property (c_q == 3'b001 && q && $rose(serial_clk_o) |-> pin_ten_o) else $error("high");
  sync_lo_a: assert property (c_q == 3'b101 && q && $rose(serial_clk_o) |-> !pin_ten_o) else $error("low");
  flag_len_a: assert property (c_q[1:0] == 2'b11 && $rose(pin_eleven_o) |=> !pin_eleven_o) else $error("pulse");
  flag_why_a: assert property (c_q[1:0] == 2'b11 && $rose(pin_eleven_o) |-> !busy_o && h_q != 3'h0)
    else $error("cause");
  busy_len_a: assert property (conv_start_i && !busy_o |=> busy_o ##79 busy_o ##1 !busy_o) else $error("busy");
  cover property (c_q[1:0] == 2'b11 && $rose(pin_eleven_o));
  cover property (c_q[2] && $rose(serial_clk_o));
  cover property (!c_q[0] && $fell(busy_o));
endmodule
bind sfsem_top sfsem_chk i_chk (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .conv_start_i, .conv_data_i,
  .busy_o, .serial_clk_o, .pin_ten_o, .pin_eleven_o);

/* File: bench/sfsem_host.sv */
`timescale 1ns/1ps
module sfsem_host (
  input  wire        go_i,
  input  wire [4:0]  n_i,
  input  wire        sdo_i,
  output reg         sclk_o = 1'b0,
  output reg  [15:0] word_o
);
  // link clock runs only inside a frame; a short frame leaves the read open
  always @(posedge go_i) begin
    repeat (n_i) begin
      #80 sclk_o = 1'b1;
      word_o = {word_o[14:0], sdo_i};
      #80 sclk_o = 1'b0;
    end
  end
endmodule

/* File: hdl/sfsem_map.vh */
`ifndef SFSEM_MAP_VH
`define SFSEM_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SFSEM_ADDR_W        4
`define SFSEM_REG_CTRL      4'h0
`define SFSEM_REG_STATUS    4'h4
`define SFSEM_REG_MASK      4'h8
`define SFSEM_REG_RESULT    4'hC
// ----------------------------------------
// control fields
// ----------------------------------------
`define SFSEM_CTRL_SER      0
`define SFSEM_CTRL_EXT      1
`define SFSEM_CTRL_INV      2
`define SFSEM_CTRL_RST      32'h0000_0000
// ----------------------------------------
// status / mask fields
// ----------------------------------------
`define SFSEM_ST_DONE       0
`define SFSEM_ST_OVR        1
`define SFSEM_ST_W          2
// ----------------------------------------
// timing
// ----------------------------------------
`define SFSEM_CONV_NS       640
`define SFSEM_CONV_CYC      ((`SFSEM_CONV_NS + 7) / 8)
`define SFSEM_INT_DIV       8
`define SFSEM_BITS          16
`endif

/* File: hdl/sfsem_top.v */
`timescale 1ns/1ps
`include "sfsem_map.vh"
module sfsem_top (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output wire        irq_o,
  input  wire        conv_start_i,
  input  wire [15:0] conv_data_i,
  input  wire        ext_sclk_i,
  output reg         busy_o,
  output reg         serial_clk_o,
  output reg         serial_data_out_o,
  output reg         pin_ten_o,
  output reg         pin_eleven_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [31:0] ctrl_q;
  wire [1:0]  status_q;
  reg  [1:0]  mask_q;
  reg  [15:0] result_q;
  wire        interface_select      = ctrl_q[`SFSEM_CTRL_SER];
  wire        clock_source_select   = ctrl_q[`SFSEM_CTRL_EXT];
  wire        frame_polarity_invert = ctrl_q[`SFSEM_CTRL_INV];
  // ----------------------------------------
  // counts, cut to the width of their counters
  // ----------------------------------------
  localparam integer CONV_CYC = `SFSEM_CONV_CYC;
  localparam integer N_BITS   = `SFSEM_BITS;
  localparam integer DIV_LAST = `SFSEM_INT_DIV - 1;
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // one-hot select: bit0 ctrl, bit1 status, bit2 mask, bit3 result
  function [3:0] sfsem_sel;
    input [3:0] a;
    begin
      if (a == `SFSEM_REG_CTRL)
        sfsem_sel = 4'h1;
      else if (a == `SFSEM_REG_STATUS)
        sfsem_sel = 4'h2;
      else if (a == `SFSEM_REG_MASK)
        sfsem_sel = 4'h4;
      else if (a == `SFSEM_REG_RESULT)
        sfsem_sel = 4'h8;
      else
        sfsem_sel = 4'h0;
    end
  endfunction
  // ----------------------------------------
  // external clock synchroniser
  // ----------------------------------------
  // sclk_m_q may go metastable; only sclk_s_q reads it
  reg        sclk_m_q;
  reg        sclk_s_q;
  reg        sclk_p_q;
  wire       ext_fall = ~sclk_s_q & sclk_p_q;
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
    end else begin
      sclk_m_q <= ext_sclk_i;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
    end
  end
  // ----------------------------------------
  // conversion timer
  // ----------------------------------------
  reg  [7:0]  conv_cnt_q;
  wire        conv_done = busy_o && (conv_cnt_q == 8'd1);
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      busy_o     <= 1'b0;
      conv_cnt_q <= 8'h00;
    end else if (conv_start_i && !busy_o) begin
      busy_o     <= 1'b1;
      conv_cnt_q <= CONV_CYC[7:0];
    end else if (busy_o) begin
      conv_cnt_q <= conv_cnt_q - 8'd1;
      if (conv_done)
        busy_o <= 1'b0;
    end
  end
  // ----------------------------------------
  // serial shifter
  // ----------------------------------------
  reg  [15:0] shift_q;
  reg  [4:0]  bits_q;
  reg         reading_q;
  reg  [2:0]  div_q;
  reg         ovr_pulse_q;
  wire        div_tick = (div_q == DIV_LAST[2:0]);
  // internal master clock: shift on falling internal edge
  // limitation: a completion during an internal read restarts it
  wire        int_shift = !clock_source_select && div_tick && serial_clk_o;
  wire        shift_ev  = clock_source_select ? ext_fall : int_shift;
  wire        ovr_ev    = conv_done && reading_q && clock_source_select;
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      shift_q           <= 16'h0000;
      bits_q            <= 5'd0;
      reading_q         <= 1'b0;
      div_q             <= 3'd0;
      serial_clk_o      <= 1'b0;
      serial_data_out_o <= 1'b0;
      ovr_pulse_q       <= 1'b0;
      result_q          <= 16'h0000;
    end else begin
      ovr_pulse_q <= ovr_ev;
      div_q       <= reading_q && !clock_source_select ? div_q + 3'd1 : 3'd0;
      if (reading_q && !clock_source_select && div_tick)
        serial_clk_o <= ~serial_clk_o;
      else if (!reading_q)
        serial_clk_o <= 1'b0;
      if (conv_done && !ovr_ev) begin
        // result latched; read starts at once when interface_select picks serial
        result_q          <= conv_data_i;
        shift_q           <= {conv_data_i[14:0], 1'b0};
        serial_data_out_o <= conv_data_i[15];
        bits_q            <= N_BITS[4:0];
        reading_q         <= interface_select;
      end else if (ovr_ev) begin
        // older result kept, the new one is dropped with the read
        reading_q <= 1'b0;
        bits_q    <= 5'd0;
      end else if (reading_q && shift_ev) begin
        if (bits_q == 5'd1) begin
          reading_q <= 1'b0;
          bits_q    <= 5'd0;
        end else begin
          serial_data_out_o <= shift_q[15];
          shift_q           <= {shift_q[14:0], 1'b0};
          bits_q            <= bits_q - 5'd1;
        end
      end
    end
  end
  // ----------------------------------------
  // shared pins
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pin_ten_o    <= 1'b0;
      pin_eleven_o <= 1'b0;
    end else if (!interface_select) begin
      pin_ten_o    <= result_q[10];
      pin_eleven_o <= result_q[11];
    end else begin
      // sync asserts only in internal-clock mode
      // external-clock mode leaves sync at its idle level
      pin_ten_o    <= frame_polarity_invert ^ (reading_q && !clock_source_select);
      pin_eleven_o <= clock_source_select & ovr_pulse_q;
    end
  end
  // ----------------------------------------
  // interrupt status and bus
  // ----------------------------------------
  wire [1:0] ev    = {ovr_ev, conv_done};
  wire [3:0] sel   = sfsem_sel(addr_i);
  wire       wr_st = wr_i && sel[1];
  // level output, combinational AND-OR of the status_q and mask_q flops
  assign irq_o = |(status_q & mask_q);
  genvar g;
  generate
    for (g = 0; g < `SFSEM_ST_W; g = g + 1) begin : g_status
      reg st_q;
      always @(posedge clk_sys_i) begin
        if (!nrst_i)
          st_q <= 1'b0;
        else if (ev[g])
          st_q <= 1'b1; // set beats clear in the same cycle
        else if (wr_st && wdata_i[g])
          st_q <= 1'b0;
      end
      assign status_q[g] = st_q;
    end
  endgenerate
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ctrl_q   <= `SFSEM_CTRL_RST;
      mask_q   <= 2'b00;
      rdata_o  <= 32'h0000_0000;
    end else begin
      if (wr_i && sel[0])
        ctrl_q <= {29'd0, wdata_i[2:0]};
      else if (wr_i && sel[2])
        mask_q <= wdata_i[1:0];
      // read data stand for one cycle only
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        if (sel[0])
          rdata_o <= ctrl_q;
        else if (sel[1])
          rdata_o <= {27'd0, busy_o, reading_q, 1'b0, status_q};
        else if (sel[2])
          rdata_o <= {30'd0, mask_q};
        else if (sel[3])
          rdata_o <= {16'd0, result_q};
      end
    end
  end
endmodule
